//--- rtl/tw_pkg.sv
// Shared constants and types for the two-wire EEPROM host controller
package tw_pkg;

   // ------------------------------------------------------------------
   // Clock and link timing
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 40;       // System clock period
   localparam int SCL_PERIOD_NS = 2500;     // Fastest legal bus rate
   // Quarter of a bus bit, rounded up so the bus never runs too fast
   localparam int QTR_CYC =
      (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
   localparam logic [4:0] QTR_LAST = 5'(QTR_CYC - 1);
   localparam int WR_CYCLE_US = 5000;       // Longest programming cycle
   localparam int WR_TIMEOUT_CYC = WR_CYCLE_US * 1000 / CLK_PERIOD_NS;
   localparam logic [3:0] RECOV_PULSES = 4'h9;  // Bus recovery clocks

   // ------------------------------------------------------------------
   // Slave addressing
   // ------------------------------------------------------------------
   localparam logic [3:0] TYPE_CODE = 4'ha;     // Fixed 1010 pattern
   localparam logic       RW_READ   = 1'b1;
   localparam logic       RW_WRITE  = 1'b0;
   localparam logic [3:0] BIT_ACK   = 4'h8;     // Ninth bit of a byte
   localparam logic [3:0] BIT_LAST  = 4'h7;     // Last data bit

   // ------------------------------------------------------------------
   // Transaction steps (what the current bus action belongs to)
   // ------------------------------------------------------------------
   localparam logic [2:0] J_CTRLW = 3'h0;   // Address byte, write
   localparam logic [2:0] J_ADDR  = 3'h1;   // Byte address
   localparam logic [2:0] J_DATA  = 3'h2;   // Write data bytes
   localparam logic [2:0] J_WSTOP = 3'h3;   // Stop that starts programming
   localparam logic [2:0] J_POLL  = 3'h4;   // Acknowledge polling
   localparam logic [2:0] J_CTRLR = 3'h5;   // Address byte, read
   localparam logic [2:0] J_END   = 3'h6;   // Final stop of a command
   localparam logic [2:0] J_RECOV = 3'h7;   // Bus recovery

   typedef enum logic [5:0] {
      ST_IDLE  = 6'b000001,
      ST_RECOV = 6'b000010,
      ST_START = 6'b000100,
      ST_TX    = 6'b001000,
      ST_RX    = 6'b010000,
      ST_STOP  = 6'b100000
   } tw_state_e;

   typedef struct packed {
      tw_state_e   state;
      logic [2:0]  job;
      logic [1:0]  phase;
      logic [4:0]  qtr;
      logic [3:0]  bitn;
      logic [7:0]  shift;
      logic [4:0]  cnt;
      logic [3:0]  len;
      logic [10:0] addr;
      logic        rd;
      logic        random;
      logic        nack;
      logic        err;
      logic [3:0]  recov_n;
      logic [16:0] to_cnt;
      logic        sda_s1;
      logic        sda_s2;
      logic        scl;
      logic        sda_oe;
      logic [7:0]  rd_data;
      logic        rd_valid;
      logic        done;
      logic        done_err;
      logic        cmd_ready;
   } tw_st_s;

   // Address byte: type code, block select, direction
   function automatic logic [7:0] ctrl_byte(input logic [2:0] blk,
                                            input logic       rw);
      ctrl_byte = {TYPE_CODE, blk, rw};
   endfunction : ctrl_byte

endpackage : tw_pkg

//--- rtl/tw_page_mem.sv
// Sixteen-byte page buffer with registered read data
`timescale 1ns/10ps
module tw_page_mem
   import tw_pkg::*;
(
   input  wire logic       i_clk,     // System clock
   input  wire logic       i_we,      // Write strobe
   input  wire logic [3:0] i_waddr,   // Write index
   input  wire logic [7:0] i_wdata,   // Write byte
   input  wire logic [3:0] i_raddr,   // Read index
   output logic      [7:0] o_rdata    // Read byte, one cycle late
);

   logic [7:0] mem [16];

   // ------------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------------
   // No reset: contents are defined by the user before a page write
   always_ff @(posedge i_clk)
   begin
      if (i_we)
      begin
         mem[i_waddr] <= i_wdata;
      end
      o_rdata <= mem[i_raddr];
   end

endmodule : tw_page_mem

//--- rtl/tw_host.sv
// Two-wire bus master that writes and reads a 2048-byte serial EEPROM
//
// Notes on behaviour
// [RULE_01] Every command opens with SDA falling while SCL is high.
// [RULE_02] Every command closes with SDA rising while SCL is high.
// [RULE_03] SDA changes only while SCL low; one SCL pulse per bit.
// [RULE_04] Receiver pulls SDA low on the ninth clock of each byte.
// [RULE_05] After reset, clock SCL up to nine times, then Start.
// [RULE_06] Address byte opens with the fixed 1010 type pattern.
// [RULE_07] Next three address bits pick one of eight 256-byte blocks.
// [RULE_08] Last address bit: one reads, zero writes.
// [RULE_09] Device acknowledges a matching address byte, then acts.
// [RULE_10] Byte write: Start, address, byte address, data, Stop.
// [RULE_11] Device ignores all requests while programming.
// [RULE_12] Page write carries up to sixteen data bytes.
// [RULE_13] Device steps only the low four address bits on writes.
// [RULE_14] Over sixteen bytes wrap inside the page and overwrite.
// [RULE_15] Device programs the whole page after Stop, inputs off.
// [RULE_16] Poll with Start plus write address until acknowledged.
// [RULE_17] Current read returns byte at last address plus one.
// [RULE_18] Single read ends with no acknowledge, then Stop.
// [RULE_19] Random read: dummy write, repeated Start, read address.
// [RULE_20] Sequential read: acknowledge for more, last unacknowledged.
// [RULE_21] Device read counter wraps from top address to zero.
// [RULE_22] Device goes to standby after idle, reads, or programming.
// [RULE_23] Device blocks all writes while write protect is high.
// [RULE_24] Internal programming finishes within five milliseconds.
// [RULE_25] Array holds 2048 bytes on an eleven-bit address.
// [RULE_26] Memory address is block select bits over byte address.
// [RULE_27] Protected writes still handshake but never program.
`timescale 1ns/10ps
module tw_host
   import tw_pkg::*;
#(
   parameter int P_WR_TIMEOUT_CYC = WR_TIMEOUT_CYC  // Polling time limit
)
(
   input  wire logic        I_CLOCK,        // 25 MHz system clock
   input  wire logic        I_SYS_RST,      // Synchronous reset, high
   input  wire logic        I_CMD_VALID,    // Command request
   input  wire logic        I_CMD_READ,     // 1 read, 0 write
   input  wire logic        I_CMD_RANDOM,   // Read: set address first
   input  wire logic [10:0] I_CMD_ADDR,     // Memory address
   input  wire logic [3:0]  I_CMD_LEN,      // Byte count minus one
   input  wire logic        I_LOAD_VALID,   // Page buffer write strobe
   input  wire logic [3:0]  I_LOAD_INDEX,   // Page buffer index
   input  wire logic [7:0]  I_LOAD_DATA,    // Page buffer byte
   input  wire logic        I_SDA,          // SDA wire level
   output logic             O_SDA_OUT,      // SDA drive value, always 0
   output logic             O_SDA_OE,       // SDA pulled low when high
   output logic             O_SCL,          // Bus clock
   output logic             O_CMD_READY,    // Idle, command accepted
   output logic [7:0]       O_RD_DATA,      // Byte read from memory
   output logic             O_RD_VALID,     // Read byte strobe
   output logic             O_DONE,         // Command finished strobe
   output logic             O_ERROR         // Failure flag with done
);

   tw_st_s     st;
   tw_st_s     next_st;
   logic [7:0] mem_rdata;
   logic       tick;
   logic       last_rd;
   logic       last_wr;

   // ------------------------------------------------------------------
   // Page buffer
   // ------------------------------------------------------------------
   // Index is the data byte about to go out; it is stable for many
   // cycles before use, which covers the registered read latency
   tw_page_mem u_page_mem
   (
      .i_clk   (I_CLOCK),
      .i_we    (I_LOAD_VALID),
      .i_waddr (I_LOAD_INDEX),
      .i_wdata (I_LOAD_DATA),
      .i_raddr (st.cnt[3:0]),
      .o_rdata (mem_rdata)
   );

   // Quarter-bit enable and end-of-transfer decodes
   assign tick    = (st.qtr == QTR_LAST);
   assign last_rd = (st.cnt == {1'b0, st.len});
   assign last_wr = (st.cnt == 5'({1'b0, st.len} + 5'h1));

   // ------------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------------
   always_comb
   begin
      next_st          = st;
      next_st.sda_s1   = I_SDA;
      next_st.sda_s2   = st.sda_s1;
      next_st.rd_valid = 1'b0;
      next_st.done     = 1'b0;
      next_st.qtr      = tick ? 5'h0 : 5'(st.qtr + 5'h1);
      // Programming-time guard runs only while polling
      if (st.job == J_POLL && st.to_cnt != 17'h1ffff)
      begin
         next_st.to_cnt = 17'(st.to_cnt + 17'h1);
      end
      if (tick && st.state != ST_IDLE)
      begin
         next_st.phase = 2'(st.phase + 2'h1);
      end
      case (st.state)
         ST_IDLE:
         begin
            next_st.phase = 2'h0;
            if (I_CMD_VALID)
            begin
               next_st.rd      = I_CMD_READ;
               next_st.random  = I_CMD_RANDOM;
               next_st.addr    = I_CMD_ADDR;
               next_st.len     = I_CMD_LEN;
               next_st.cnt     = 5'h0;
               next_st.err     = 1'b0;
               next_st.to_cnt  = 17'h0;
               // Current-address read skips the byte address
               next_st.job     = (I_CMD_READ && !I_CMD_RANDOM) ?
                                 J_CTRLR : J_CTRLW;
               next_st.state   = ST_START;
               next_st.cmd_ready = 1'b0;
            end
         end
         // Free a slave stuck mid-byte: pulse SCL until SDA reads high, at most nine times
         ST_RECOV:
         begin
            if (tick)
            begin
               case (st.phase)
                  2'h0: next_st.sda_oe = 1'b0;
                  2'h1: next_st.scl = 1'b1;                   // [RULE_05]
                  2'h2:
                  begin
                     if (st.sda_s2 || st.recov_n == RECOV_PULSES)
                     begin
                        next_st.job   = J_RECOV;              // [RULE_05]
                        next_st.state = ST_START;
                        next_st.phase = 2'h0;
                     end
                  end
                  default:
                  begin
                     next_st.scl     = 1'b0;
                     next_st.recov_n = 4'(st.recov_n + 4'h1);
                  end
               endcase
            end
         end
         // Start or repeated Start: SDA falls in the SCL high time
         ST_START:
         begin
            if (tick)
            begin
               case (st.phase)
                  2'h0: next_st.sda_oe = 1'b0;
                  2'h1: next_st.scl = 1'b1;
                  2'h2: next_st.sda_oe = 1'b1;                // [RULE_01]
                  default:
                  begin
                     next_st.scl  = 1'b0;
                     next_st.bitn = 4'h0;
                     next_st.nack = 1'b0;
                     if (st.job == J_RECOV)
                     begin
                        next_st.state = ST_STOP;
                     end
                     else
                     begin
                        // [RULE_06] [RULE_07] [RULE_08] [RULE_26]
                        next_st.shift = ctrl_byte(st.addr[10:8],
                           (st.job == J_CTRLR) ? RW_READ : RW_WRITE);
                        next_st.state = ST_TX;
                     end
                  end
               endcase
            end
         end
         // Send eight bits, then release SDA for the slave's answer
         ST_TX:
         begin
            if (tick)
            begin
               case (st.phase)
                  2'h0: next_st.sda_oe = (st.bitn != BIT_ACK) ?
                                         ~st.shift[7] : 1'b0; // [RULE_03]
                  2'h1: next_st.scl = 1'b1;                   // [RULE_03]
                  2'h2:
                  begin
                     if (st.bitn == BIT_ACK)
                     begin
                        next_st.nack = st.sda_s2;             // [RULE_04]
                     end
                  end
                  default:
                  begin
                     next_st.scl  = 1'b0;
                     next_st.bitn = 4'(st.bitn + 4'h1);
                     next_st.shift = {st.shift[6:0], 1'b0};
                     if (st.bitn == BIT_ACK)
                     begin
                        next_st.bitn = 4'h0;
                        if (st.nack)
                        begin
                           // Busy device stays silent while it programs
                           next_st.err   = (st.job != J_POLL); // [RULE_11]
                           next_st.job   = (st.job == J_POLL) ?
                                           J_POLL : J_END;    // [RULE_16]
                           next_st.state = ST_STOP;
                        end
                        else
                        begin
                           case (st.job)
                              J_CTRLW:
                              begin
                                 next_st.shift = st.addr[7:0]; // [RULE_10]
                                 next_st.job   = J_ADDR;
                              end
                              J_ADDR:
                              begin
                                 if (st.rd)
                                 begin
                                    next_st.job   = J_CTRLR;  // [RULE_19]
                                    next_st.state = ST_START;
                                 end
                                 else
                                 begin
                                    next_st.shift = mem_rdata;
                                    next_st.cnt   = 5'(st.cnt + 5'h1);
                                    next_st.job   = J_DATA;
                                 end
                              end
                              J_DATA:
                              begin
                                 // At most sixteen bytes so the page
                                 // never wraps onto itself
                                 if (last_wr)
                                 begin
                                    next_st.job   = J_WSTOP;  // [RULE_12]
                                    next_st.state = ST_STOP;
                                 end
                                 else
                                 begin
                                    next_st.shift = mem_rdata;
                                    next_st.cnt   = 5'(st.cnt + 5'h1);
                                 end
                              end
                              J_CTRLR:
                              begin
                                 next_st.cnt   = 5'h0;        // [RULE_09]
                                 next_st.job   = J_END;
                                 next_st.state = ST_RX;
                              end
                              default:
                              begin
                                 next_st.job   = J_END;       // [RULE_16]
                                 next_st.state = ST_STOP;
                              end
                           endcase
                        end
                     end
                  end
               endcase
            end
         end
         // Receive eight bits, then acknowledge all but the last byte
         ST_RX:
         begin
            if (tick)
            begin
               case (st.phase)
                  2'h0: next_st.sda_oe = (st.bitn == BIT_ACK) ?
                                         ~last_rd : 1'b0;     // [RULE_20]
                  2'h1: next_st.scl = 1'b1;
                  2'h2:
                  begin
                     if (st.bitn != BIT_ACK)
                     begin
                        next_st.shift = {st.shift[6:0], st.sda_s2};
                     end
                  end
                  default:
                  begin
                     next_st.scl  = 1'b0;
                     next_st.bitn = 4'(st.bitn + 4'h1);
                     if (st.bitn == BIT_LAST)
                     begin
                        next_st.rd_data  = st.shift;
                        next_st.rd_valid = 1'b1;
                     end
                     if (st.bitn == BIT_ACK)
                     begin
                        next_st.bitn = 4'h0;
                        next_st.cnt  = 5'(st.cnt + 5'h1);
                        if (last_rd)
                        begin
                           next_st.job   = J_END;             // [RULE_18]
                           next_st.state = ST_STOP;
                        end
                     end
                  end
               endcase
            end
         end
         // Stop: SDA rises in the SCL high time
         ST_STOP:
         begin
            if (tick)
            begin
               case (st.phase)
                  2'h0: next_st.sda_oe = 1'b1;
                  2'h1: next_st.scl = 1'b1;
                  2'h2: next_st.sda_oe = 1'b0;                // [RULE_02]
                  default:
                  begin
                     case (st.job)
                        J_WSTOP:
                        begin
                           // Programming has begun; poll right away
                           next_st.job    = J_POLL;           // [RULE_16]
                           next_st.to_cnt = 17'h0;
                           next_st.state  = ST_START;
                        end
                        J_POLL:
                        begin
                           if (st.to_cnt >= 17'(P_WR_TIMEOUT_CYC))
                           begin
                              next_st.err   = 1'b1;           // [RULE_24]
                              next_st.job   = J_END;
                              next_st.done  = 1'b1;
                              next_st.state = ST_IDLE;
                              next_st.cmd_ready = 1'b1;
                           end
                           else
                           begin
                              next_st.state = ST_START;       // [RULE_16]
                           end
                        end
                        J_RECOV:
                        begin
                           next_st.job   = J_END;
                           next_st.state = ST_IDLE;
                           next_st.cmd_ready = 1'b1;
                        end
                        default:
                        begin
                           next_st.done  = 1'b1;              // [RULE_02]
                           next_st.state = ST_IDLE;
                           next_st.cmd_ready = 1'b1;
                        end
                     endcase
                     next_st.done_err = next_st.err;
                  end
               endcase
            end
         end
         default:
         begin
            next_st.state = ST_RECOV;
         end
      endcase
   end

   // ------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------
   // Reset leaves the bus idle-high and runs recovery before any command
   always_ff @(posedge I_CLOCK)
   begin
      if (I_SYS_RST)
      begin
         st           <= '0;
         st.state     <= ST_RECOV;
         st.job       <= J_RECOV;
         st.scl       <= 1'b1;
         st.sda_s1    <= 1'b1;
         st.sda_s2    <= 1'b1;
      end
      else
      begin
         st <= next_st;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign O_SDA_OUT   = 1'b0;   // Open drain: only ever pulls low
   assign O_SDA_OE    = st.sda_oe;
   assign O_SCL       = st.scl;
   assign O_CMD_READY = st.cmd_ready;
   assign O_RD_DATA   = st.rd_data;
   assign O_RD_VALID  = st.rd_valid;
   assign O_DONE      = st.done;
   assign O_ERROR     = st.done_err;

endmodule : tw_host

//--- rtl/tw_fix_note.sv
// Spare design unit: no logic lives here

//--- sim/tw_chk.sv
// Port-level assertions for the two-wire host
`timescale 1ns/10ps
module tw_chk
(
   input wire logic I_CLOCK,     // System clock
   input wire logic I_SYS_RST,   // Synchronous reset
   input wire logic I_CMD_VALID, // Command request
   input wire logic O_SDA_OUT,   // SDA drive value
   input wire logic O_SDA_OE,    // SDA pull-down enable
   input wire logic O_SCL,       // Bus clock
   input wire logic O_CMD_READY, // Idle flag
   input wire logic O_RD_VALID   // Read byte strobe
);
   // One clock domain; reset only silences, except for the reset check
   default clocking cb @(posedge I_CLOCK); endclocking
   default disable iff (I_SYS_RST);
   property p_rst_idle; disable iff (1'b0) I_SYS_RST |=>
      O_SCL && !O_SDA_OE && !O_CMD_READY && !O_RD_VALID; endproperty
   a_rst_idle: assert property (p_rst_idle) else $error("bus busy");
   // SDA may not move while SCL is high, short of Start or Stop
   property p_sda_hold; $rose(O_SCL) |-> $stable(O_SDA_OE) [*8]; endproperty
   a_sda_hold: assert property (p_sda_hold) else $error("sda moved");
   property p_sda_fall; $fell(O_SCL) |-> $stable(O_SDA_OE); endproperty
   a_sda_fall: assert property (p_sda_fall) else $error("sda skew");
   // Open drain: the pin only ever pulls low
   property p_drain; O_SDA_OUT == 1'b0; endproperty
   a_drain: assert property (p_drain) else $error("sda drives high");
   property p_take; I_CMD_VALID && O_CMD_READY |=> !O_CMD_READY; endproperty
   a_take: assert property (p_take) else $error("command not taken");
   property p_hold; O_CMD_READY && !I_CMD_VALID |=> O_CMD_READY; endproperty
   a_hold: assert property (p_hold) else $error("ready dropped");
   // An idle host leaves both lines released high after its Stop
   property p_idle; O_CMD_READY |-> O_SCL && !O_SDA_OE; endproperty
   a_idle: assert property (p_idle) else $error("bus not idle");
   property p_rx; O_RD_VALID |-> !O_SDA_OE; endproperty
   a_rx: assert property (p_rx) else $error("sda driven in read");
endmodule : tw_chk

//--- sim/tw_eeprom_model.sv
// Behavioural two-wire EEPROM on the wire
`timescale 1ns/10ps
module tw_eeprom_model
#(
   parameter int P_WR_NS = 40000    // Programming time, under 5 ms
)
(
   input  wire logic i_scl,         // Bus clock from host
   input  wire logic i_sda,         // Wire level of SDA
   input  wire logic i_wp,          // High blocks writes
   output logic      o_sda_oe       // High while pulling SDA low
);
   logic [7:0]  mem [2048];
   logic [7:0]  wq_d [$];
   logic [10:0] wq_a [$];
   logic [10:0] ptr = 11'h0;
   logic [7:0]  sh, tx;
   logic        act = 0, busy = 0, rd = 0, send = 0, mack;
   int          bitc, st;
   initial foreach (mem[i]) mem[i] = 8'(i * 3);
   initial o_sda_oe = 0;
   // Start keeps the address; count -1 as its own SCL fall counts
   always @(negedge i_sda) if (i_scl)
   begin
      {act, rd, send, bitc, st} = {3'b100, 32'(-1), 32'd0};
      o_sda_oe <= 0;
   end
   // Stop programs what was received; stops are missed while busy
   always @(posedge i_sda) if (i_scl)
   begin
      act = 0;
      if (!i_wp) foreach (wq_a[k]) mem[wq_a[k]] = wq_d[k];
      busy = (wq_a.size() > 0) && !i_wp;
      wq_a.delete();
      wq_d.delete();
      if (busy) #(P_WR_NS) busy = 0;
   end
   always @(posedge i_scl) if (act)
      if (bitc < 8) sh = {sh[6:0], i_sda}; else mack = i_sda;
   // Drive only after SCL falls, so SDA never moves while SCL is high
   always @(negedge i_scl) if (act)
   begin
      bitc = bitc + 1;
      if (bitc < 8 && rd) o_sda_oe <= ~tx[7 - bitc];
      else if (bitc == 8 && rd) o_sda_oe <= 0;
      else if (bitc == 8)
      begin
         if (st == 0 && sh[7:4] == 4'ha && !busy)
            {ptr[10:8], send} = sh[3:0];
         else if (st == 1) ptr[7:0] = sh;
         else if (st == 2)
         begin
            wq_a.push_back(ptr);
            wq_d.push_back(sh);
            ptr[3:0] = ptr[3:0] + 4'h1;
         end
         else act = 0;
         o_sda_oe <= act;
         st = (st < 2) ? st + 1 : 2;
      end
      else if (bitc == 9)
      begin
         bitc = 0;
         rd = send || (rd && !mack);
         if (rd) {tx, ptr} = {mem[ptr], ptr + 11'h1};
         o_sda_oe <= rd && !tx[7];
         send = 0;
      end
   end
endmodule : tw_eeprom_model

//--- sim/testbench.sv
// Self-checking bench: host against a behavioural EEPROM
`timescale 1ns/10ps
module testbench;
   import tw_pkg::*;
   logic        clk = 0, rst = 1, cv = 0, cr = 0, cm = 0, lv = 0, wp = 0;
   logic [10:0] ca = 0;
   logic [3:0]  cl = 0, li = 0;
   logic [7:0]  ld = 0, rdd;
   logic        sda_oe, dev_oe, scl, rdy, rdv, done, err;
   logic [7:0]  rdq [$], ex [$];
   int          miscompares = 0, checked = 0, cyc = 0;
   wire         sda = !(sda_oe | dev_oe);   // Pull-up wire
   always #20 clk = ~clk;
   tw_host #(.P_WR_TIMEOUT_CYC(2000)) tw_host_inst (.I_CLOCK(clk),
      .I_SYS_RST(rst), .I_CMD_VALID(cv), .I_CMD_READ(cr), .I_CMD_RANDOM(cm),
      .I_CMD_ADDR(ca), .I_CMD_LEN(cl), .I_LOAD_VALID(lv), .I_LOAD_INDEX(li),
      .I_LOAD_DATA(ld), .I_SDA(sda), .O_SDA_OUT(), .O_SDA_OE(sda_oe),
      .O_SCL(scl), .O_CMD_READY(rdy), .O_RD_DATA(rdd), .O_RD_VALID(rdv),
      .O_DONE(done), .O_ERROR(err));
   tw_eeprom_model tw_eeprom_model_inst (.i_scl(scl), .i_sda(sda),
      .i_wp(wp), .o_sda_oe(dev_oe));
   always @(posedge clk) if (rdv === 1'b1) rdq.push_back(rdd);
   // Hang guard: about three times the expected run
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 90000) begin miscompares++; results(); end
   end
   function automatic logic [7:0] iv(input logic [10:0] a);
      iv = 8'(a * 3);
   endfunction : iv
   task chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task cmd(input logic r, input logic m, input logic [10:0] a,
            input logic [3:0] l);
      int n;
      n = 0;
      while (rdy !== 1'b1 && n < 9000) begin @(posedge clk); #1 n++; end
      {cv, cr, cm, ca, cl} = {1'b1, r, m, a, l};
      @(posedge clk);
      #1 cv = 0;
      n = 0;
      while (done !== 1'b1 && n < 40000) begin @(posedge clk); #1 n++; end
      chk({7'h0, err | (done !== 1'b1)}, 8'h0);
   endtask : cmd
   // Byte k of a write is 40h plus k, loaded one per cycle
   task wr(input logic [10:0] a, input int n);
      lv = 1;
      for (int k = 0; k < n; k++)
      begin
         {li, ld} = {4'(k), 8'h40 + 8'(k)};
         @(posedge clk);
         #1;
      end
      lv = 0;
      cmd(1'b0, 1'b0, a, 4'(n - 1));
   endtask : wr
   task rd(input logic m, input logic [10:0] a, input logic [3:0] l);
      rdq.delete();
      cmd(1'b1, m, a, l);
      chk(8'(rdq.size()), 8'(l) + 8'h1);
      foreach (ex[k]) chk(rdq[k], ex[k]);
   endtask : rd
   task t_page();
      wr(11'h1fe, 4);
      ex.delete();
      for (int k = 0; k < 16; k++) ex.push_back(iv(11'h1f0 + 11'(k)));
      {ex[14], ex[15], ex[0], ex[1]} = 32'h40414243;
      rd(1'b1, 11'h1f0, 4'hf);
   endtask : t_page
   task t_top();
      ex = '{iv(11'h7fe), iv(11'h7ff), iv(11'h0), iv(11'h1)};
      rd(1'b1, 11'h7fe, 4'h3);
   endtask : t_top
   task t_cur();
      ex = '{iv(11'h2)};
      rd(1'b0, 11'h0, 4'h0);
   endtask : t_cur
   task t_prot();
      wp = 1;
      wr(11'h321, 1);
      wp = 0;
      ex = '{iv(11'h321)};
      rd(1'b1, 11'h321, 4'h0);
   endtask : t_prot
   task results();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : results
   initial
   begin
      repeat (6) @(posedge clk);
      #1 rst = 0;
      t_page();
      t_top();
      t_cur();
      t_prot();
      results();
   end
endmodule : testbench
bind tw_host tw_chk tw_chk_inst (.I_CLOCK(I_CLOCK), .I_SYS_RST(I_SYS_RST),
   .I_CMD_VALID(I_CMD_VALID), .O_SDA_OUT(O_SDA_OUT), .O_SDA_OE(O_SDA_OE),
   .O_SCL(O_SCL), .O_CMD_READY(O_CMD_READY), .O_RD_VALID(O_RD_VALID));
